//--- design/mrp_defs.svh
// Constants for mode register programming: fields, codes and timings
`ifndef MRP_DEFS_SVH
`define MRP_DEFS_SVH
// Address field positions of mode register 0
`define MRP_BL_LSB        0
`define MRP_CL_LOW_BIT    2
`define MRP_RBO_BIT       3
`define MRP_CL_LSB        4
`define MRP_TM_BIT        7
`define MRP_DLLRST_BIT    8
`define MRP_WR_LSB        9
`define MRP_PPD_BIT       12
`define MRP_RSV_LSB       13
// Burst length codes
`define MRP_BL_FIX8       2'h0
`define MRP_BL_OTF        2'h1
`define MRP_BL_FIX4       2'h2
`define MRP_BL_RSV        2'h3
// Reset values of the device copies (contents are undefined at power-up)
`define MRP_MR_RESET      16'h0000
// Timing in clock cycles of ref_clk_in
`define MRP_TMRD_CYC      4
`define MRP_TMOD_CYC      12
`define MRP_TDLLK_CYC     512
`define MRP_TRP_CYC       6
// APB register offsets of the controller
`define MRP_REG_CTRL      12'h000
`define MRP_REG_DATA      12'h004
`define MRP_REG_STAT      12'h008
// Control register fields
`define MRP_CTRL_GO_BIT   0
`define MRP_CTRL_SEL_LSB  1
`define MRP_CTRL_ODT_BIT  3
`define MRP_CTRL_RTT_BIT  4
`endif

//--- design/mrp_pkg.sv
// Types shared by both ends of the mode register programming link
package mrp_pkg;
  // Command encoding: cs_n, ras_n, cas_n, we_n
  typedef logic [3:0] mrp_cmd_t;
  typedef enum logic [1:0]
  {
    MRP_SEL_MR0 = 2'h0,
    MRP_SEL_MR1 = 2'h1,
    MRP_SEL_MR2 = 2'h2,
    MRP_SEL_MR3 = 2'h3
  } mrp_sel_e;
  typedef enum logic [1:0]
  {
    MRP_C_IDLE = 2'h0,
    MRP_C_ISSUE = 2'h1,
    MRP_C_WAIT = 2'h2
  } mrp_cstate_e;
endpackage : mrp_pkg

//--- design/mrp_if.sv
// Command and address link between controller and device
`timescale 1ns/100ps
interface mrp_if;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic        cke;
  logic        odt;
  logic [2:0]  ba;
  logic [15:0] addr;
  modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, odt, ba, addr);
  modport dev  (input  cs_n, ras_n, cas_n, we_n, cke, odt, ba, addr);
endinterface : mrp_if

//--- design/mrp_device.sv
// Device end: four mode registers loaded by the mode register set command
`timescale 1ns/100ps
`include "mrp_defs.svh"
// Summary of operation
// - Four mode registers, written only by MRS
// - Controller writes all registers after reset; here a register is written only on an APB order
// - MRS may rewrite registers during operation
// - Controller drives every address field
// - MRS and DLL reset keep array
// - Controller spaces MRS commands by tMRD
// - Only NOP/deselect within tMOD after MRS
// - Controller rewrites only when device idle
// - Termination input low until tMOD expires
// - Termination free when nominal termination off
// - MR0 write: all command, bank low
// - Bank bits 1:0 select register
// - Address 1:0 select burst length
// - Address 3 selects read burst order
// - DLL reset bit self-clears; wait tDLLK
// - Address 12 selects power-down DLL exit
// - Controller programs write recovery at least minimum; here the code from the data register is sent unchecked
// - Write recovery plus precharge gives tDAL
// - Reserved bank and address bits zero
module mrp_device
  import mrp_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // Link from controller
  mrp_if.dev               link,
  // Decoded mode of mode register 0, status flags and copies of registers 1 to 3
  output logic [3:0]       burst_len_out,
  output logic             burst_otf_out,
  output logic             read_burst_order_out,
  output logic [3:0]       cas_latency_out,
  output logic [4:0]       write_recovery_out,
  output logic [5:0]       dal_cycles_out,
  output logic             powerdown_dll_exit_select_out,
  output logic             vendor_test_select_out,
  output logic             dll_locked_out,
  output logic             cfg_error_out,
  output logic [15:0]      mr1_out,
  output logic [15:0]      mr2_out,
  output logic [15:0]      mr3_out
);

  typedef struct packed
  {
    logic [3:0][15:0] mr;
    logic [9:0]       dll_cnt;
    logic             dll_lock;
    logic             err;
  } mrp_dev_s;

  mrp_dev_s st_q;
  mrp_dev_s st_d;
  logic     mrs_cmd;

  // Write recovery code to cycles; zero marks a reserved code
  function automatic logic [4:0] mrp_wr_cycles(input logic [2:0] code);
    unique case (code)
      3'h1: mrp_wr_cycles = 5'h05;
      3'h2: mrp_wr_cycles = 5'h06;
      3'h3: mrp_wr_cycles = 5'h07;
      3'h4: mrp_wr_cycles = 5'h08;
      3'h5: mrp_wr_cycles = 5'h0a;
      3'h6: mrp_wr_cycles = 5'h0c;
      default: mrp_wr_cycles = 5'h00;
    endcase
  endfunction : mrp_wr_cycles

  // CAS latency: codes 1..7 map to 5..11, zero or address bit 2 set is reserved
  function automatic logic [3:0] mrp_cas(input logic [15:0] mr);
    logic [2:0] c;
    c = mr[`MRP_CL_LSB +: 3];
    if (c == 3'h0 || mr[`MRP_CL_LOW_BIT])
      mrp_cas = 4'h0;
    else
      mrp_cas = 4'(c) + 4'h4;
  endfunction : mrp_cas

  // Command decode: chip selected, RAS, CAS and WE low while CKE high
  assign mrs_cmd = link.cke && !link.cs_n && !link.ras_n
                   && !link.cas_n && !link.we_n;

  // Register writes only from MRS; array is never touched here
  always_comb
  begin
    st_d = st_q;
    if (st_q.dll_cnt != 10'h000)
    begin
      st_d.dll_cnt = st_q.dll_cnt - 10'h001;
      st_d.dll_lock = (st_q.dll_cnt == 10'h001);
    end
    if (mrs_cmd)
    begin
      st_d.mr[link.ba[1:0]] = link.addr;
      // Reserved bank bit set: flag, value still stored for debug
      st_d.err = link.ba[2]
                 || (link.addr[15:`MRP_RSV_LSB] != 3'h0);
      if (link.ba[1:0] == 2'h0 && link.addr[`MRP_DLLRST_BIT])
      begin
        // Bit self-clears once the reset is started
        st_d.mr[0][`MRP_DLLRST_BIT] = 1'b0;
        st_d.dll_cnt = 10'(`MRP_TDLLK_CYC);
        st_d.dll_lock = 1'b0;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Decoded outputs, all registered
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      burst_len_out                 <= 4'h0;
      burst_otf_out                 <= 1'b0;
      read_burst_order_out          <= 1'b0;
      cas_latency_out               <= 4'h0;
      write_recovery_out            <= 5'h00;
      dal_cycles_out                <= 6'h00;
      powerdown_dll_exit_select_out <= 1'b0;
      vendor_test_select_out        <= 1'b0;
      dll_locked_out                <= 1'b0;
      cfg_error_out                 <= 1'b0;
      mr1_out                       <= `MRP_MR_RESET;
      mr2_out                       <= `MRP_MR_RESET;
      mr3_out                       <= `MRP_MR_RESET;
    end
    else
    begin
      unique case (st_d.mr[0][`MRP_BL_LSB +: 2])
        `MRP_BL_FIX8: burst_len_out <= 4'h8;
        `MRP_BL_OTF:  burst_len_out <= 4'h8;
        `MRP_BL_FIX4: burst_len_out <= 4'h4;
        `MRP_BL_RSV:  burst_len_out <= 4'h0;
      endcase
      burst_otf_out <= (st_d.mr[0][`MRP_BL_LSB +: 2] == `MRP_BL_OTF);
      read_burst_order_out <= st_d.mr[0][`MRP_RBO_BIT];
      cas_latency_out <= mrp_cas(st_d.mr[0]);
      write_recovery_out <= mrp_wr_cycles(st_d.mr[0][`MRP_WR_LSB +: 3]);
      // tDAL = WR + tRP
      dal_cycles_out <= 6'(mrp_wr_cycles(st_d.mr[0][`MRP_WR_LSB +: 3]))
                        + 6'(`MRP_TRP_CYC);
      // Zero is slow exit with frozen DLL
      powerdown_dll_exit_select_out <= st_d.mr[0][`MRP_PPD_BIT];
      vendor_test_select_out <= st_d.mr[0][`MRP_TM_BIT];
      dll_locked_out <= st_d.dll_lock;
      cfg_error_out <= st_d.err;
      mr1_out <= st_d.mr[1];
      mr2_out <= st_d.mr[2];
      mr3_out <= st_d.mr[3];
    end
  end

endmodule : mrp_device

//--- design/mrp_ctrl.sv
// Controller end: issues MRS commands on APB order with tMRD/tMOD spacing
`timescale 1ns/100ps
`include "mrp_defs.svh"
module mrp_ctrl
  import mrp_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Link to device
  mrp_if.ctrl              link
);

  typedef struct packed
  {
    mrp_cstate_e state;
    logic [3:0]  cmd;
    logic [2:0]  ba;
    logic [15:0] addr;
    logic [15:0] data;
    logic [1:0]  sel;
    logic        odt_req;
    logic        rtt_on;
    logic        odt;
    logic [4:0]  mrd_cnt;
    logic [4:0]  mod_cnt;
    logic        go;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        cke;
  } mrp_ctl_s;

  mrp_ctl_s st_q;
  mrp_ctl_s st_d;
  logic     acc;

  assign acc = psel_in && penable_in && !st_q.ready;

  always_comb
  begin
    st_d = st_q;
    st_d.ready = acc; // one wait state
    st_d.err = 1'b0;
    st_d.cmd = 4'hf; // Deselect by default
    // Clock enable rises one cycle after reset, then stays high
    st_d.cke = 1'b1;
    if (st_q.mrd_cnt != 5'h00)
      st_d.mrd_cnt = st_q.mrd_cnt - 5'h01;
    if (st_q.mod_cnt != 5'h00)
      st_d.mod_cnt = st_q.mod_cnt - 5'h01;
    // Termination low unless off both sides; raised after tMOD
    st_d.odt = st_q.odt_req && (!st_q.rtt_on || st_q.mod_cnt == 5'h00)
               && st_q.state != MRP_C_ISSUE;
    // APB register access
    if (acc)
    begin
      st_d.rdata = 32'h0;
      if (pwrite_in)
      begin
        unique case (paddr_in)
          `MRP_REG_DATA: st_d.data = pwdata_in[15:0];
          `MRP_REG_CTRL:
          begin
            st_d.sel = pwdata_in[`MRP_CTRL_SEL_LSB +: 2];
            st_d.odt_req = pwdata_in[`MRP_CTRL_ODT_BIT];
            st_d.rtt_on = pwdata_in[`MRP_CTRL_RTT_BIT];
            if (pwdata_in[`MRP_CTRL_GO_BIT])
              st_d.go = 1'b1;
          end
          `MRP_REG_STAT: st_d.err = 1'b0;
          default: st_d.err = 1'b1;
        endcase
      end
      else
      begin
        unique case (paddr_in)
          `MRP_REG_DATA: st_d.rdata = {16'h0, st_q.data};
          `MRP_REG_CTRL: st_d.rdata = {27'h0, st_q.rtt_on, st_q.odt_req,
                                       st_q.sel, 1'b0};
          `MRP_REG_STAT: st_d.rdata = {30'h0, st_q.go,
                                       st_q.state != MRP_C_IDLE};
          default: st_d.err = 1'b1;
        endcase
      end
    end
    // Command sequencer
    unique case (st_q.state)
      MRP_C_IDLE:
        if (st_q.go && st_q.mrd_cnt == 5'h00)
        begin
          st_d.state = MRP_C_ISSUE;
          st_d.odt = st_q.odt_req && !st_q.rtt_on;
        end
      MRP_C_ISSUE:
      begin
        st_d.cmd = 4'h0;
        st_d.ba = {1'b0, st_q.sel};
        // Test mode forced off, reserved bits zero
        st_d.addr = {3'h0, st_q.data[12:8], 1'b0, st_q.data[6:0]};
        st_d.mrd_cnt = 5'(`MRP_TMRD_CYC - 1);
        st_d.mod_cnt = 5'(`MRP_TMOD_CYC - 1);
        st_d.go = 1'b0;
        st_d.state = MRP_C_WAIT;
      end
      MRP_C_WAIT:
        // Only deselect until tMOD ends
        if (st_q.mod_cnt == 5'h00)
          st_d.state = MRP_C_IDLE;
      default: st_d.state = MRP_C_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      st_q <= '{state: MRP_C_IDLE, cmd: 4'hf, default: '0};
    else
      st_q <= st_d;
  end

  // Outputs straight from flops; CKE high keeps idle
  assign link.cs_n  = st_q.cmd[3];
  assign link.ras_n = st_q.cmd[2];
  assign link.cas_n = st_q.cmd[1];
  assign link.we_n  = st_q.cmd[0];
  assign link.cke   = st_q.cke;
  assign link.odt   = st_q.odt;
  assign link.ba    = st_q.ba;
  assign link.addr  = st_q.addr;
  assign prdata_out  = st_q.rdata;
  assign pready_out  = st_q.ready;
  // Error is only set on an access, so it stands with pready
  assign pslverr_out = st_q.err;

endmodule : mrp_ctrl

//--- verif/mrp_checker.sv
// Checker of command timing and fields on the controller-device link
`timescale 1ns/100ps
`include "mrp_defs.svh"
module mrp_checker
(
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        reset_n_in,
  // Link signals
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic        cke,
  input  wire logic        odt,
  input  wire logic [2:0]  ba,
  input  wire logic [15:0] addr
);
  localparam int TMRD = `MRP_TMRD_CYC;
  localparam int TMOD = `MRP_TMOD_CYC;
  logic [4:0] since_q;
  logic       mrs;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Mode register set decode
  assign mrs = cke & ~cs_n & ~ras_n & ~cas_n & ~we_n;
  // Cycles since last MRS; starts saturated so the first MRS is free
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
    if (!reset_n_in)
      since_q <= 5'h1f;
    else if (mrs)
      since_q <= 5'h00;
    else if (since_q != 5'h1f)
      since_q <= since_q + 5'h01;
  AST_ONLY_MRS: assert property (!cs_n |-> !ras_n && !cas_n && !we_n)
    else $error("selected command is not a mode register set");
  AST_TMOD: assert property (!cs_n |-> since_q >= TMOD - 1)
    else $error("command issued inside the update delay");
  AST_TMRD: assert property (mrs |-> since_q >= TMRD - 1)
    else $error("mode register set commands too close");
  AST_RSV_ZERO: assert property (mrs |-> !ba[2] && addr[15:13] == 3'h0)
    else $error("reserved bank or address bits not zero");
  AST_TEST_OFF: assert property (mrs && ba[1:0] == 2'h0 |-> !addr[7])
    else $error("test mode bit set");
  AST_CKE_HIGH: assert property (!cs_n |-> cke)
    else $error("command with clock enable low");
  AST_ONE_CYCLE: assert property (mrs |=> cs_n [*3])
    else $error("command not followed by deselect");
  AST_RESET_IDLE: assert property ($rose(reset_n_in) |-> cs_n [*2])
    else $error("command right after reset");
  // Main scenarios reached
  COV_MR0: cover property (mrs && ba[1:0] == 2'h0);
  COV_MR3: cover property (mrs && ba[1:0] == 2'h3);
  COV_DLL: cover property (mrs && addr[8]);
endmodule : mrp_checker

//--- verif/mode_register_programming_tb.sv
// Testbench joining controller and device over the link
`timescale 1ns/100ps
`include "mrp_defs.svh"
module mode_register_programming_tb;
  import mrp_pkg::*;
  typedef struct {
    logic [15:0] a;
    logic [3:0]  bl;
    logic        otf;
    logic        rbo;
    logic [3:0]  cl;
    logic [4:0]  wr;
    logic        powerdown_dll_exit_select;
  } mrp_row_s;
  // Address word beside its decoded mode
  mrp_row_s rows[8] = '{
    '{16'h0210, 4'h8, 1'b0, 1'b0, 4'h5, 5'h05, 1'b0},
    '{16'h1429, 4'h8, 1'b1, 1'b1, 4'h6, 5'h06, 1'b1},
    '{16'h0632, 4'h4, 1'b0, 1'b0, 4'h7, 5'h07, 1'b0},
    '{16'h084b, 4'h0, 1'b0, 1'b1, 4'h8, 5'h08, 1'b0},
    '{16'h0a50, 4'h8, 1'b0, 1'b0, 4'h9, 5'h0a, 1'b0},
    '{16'h1c61, 4'h8, 1'b1, 1'b0, 4'ha, 5'h0c, 1'b1},
    '{16'h0272, 4'h4, 1'b0, 1'b0, 4'hb, 5'h05, 1'b0},
    '{16'h0400, 4'h8, 1'b0, 1'b0, 4'h0, 5'h06, 1'b0}};
  logic        ref_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic        pready;
  logic        pslverr;
  logic        rerr;
  logic        rtt_on = 1'b0;
  logic [3:0]  bl;
  logic [3:0]  cl;
  logic [4:0]  wr;
  logic [5:0]  dal;
  logic        otf;
  logic        rbo;
  logic        powerdown_dll_exit_select;
  logic        tm;
  logic        lock;
  logic        cerr;
  logic [15:0] mr1;
  logic [15:0] mr2;
  logic [15:0] mr3;
  int          error_cnt = 0;
  int          n_compared = 0;
  mrp_if mrp_if_i ();
  mrp_ctrl mrp_ctrl_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .link(mrp_if_i));
  mrp_device mrp_device_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .link(mrp_if_i), .burst_len_out(bl), .burst_otf_out(otf),
    .read_burst_order_out(rbo), .cas_latency_out(cl),
    .write_recovery_out(wr), .dal_cycles_out(dal),
    .powerdown_dll_exit_select_out(powerdown_dll_exit_select), .vendor_test_select_out(tm),
    .dll_locked_out(lock), .cfg_error_out(cerr), .mr1_out(mr1),
    .mr2_out(mr2), .mr3_out(mr3));
  mrp_checker mrp_checker_i (.ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in), .cs_n(mrp_if_i.cs_n), .ras_n(mrp_if_i.ras_n),
    .cas_n(mrp_if_i.cas_n), .we_n(mrp_if_i.we_n), .cke(mrp_if_i.cke),
    .odt(mrp_if_i.odt), .ba(mrp_if_i.ba), .addr(mrp_if_i.addr));
  // 40 MHz clock
  always #12.5 ref_clk_in = ~ref_clk_in;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task finish_test;
    $display("mismatches %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  // One APB transfer; waits on pready with a bound, never a fixed count
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Load a word into one register, then poll until the controller is idle
  task mrs(input logic [1:0] s, input logic [15:0] w, input logic rtt);
    int n;
    n = 0;
    rtt_on = rtt;
    apb(1'b1, `MRP_REG_DATA, {16'h0, w});
    apb(1'b1, `MRP_REG_CTRL, {27'h0, rtt, rtt, s, 1'b1});
    do
    begin
      apb(1'b0, `MRP_REG_STAT, 32'h0);
      n++;
    end
    while (rdata[1:0] !== 2'h0 && n < 40);
    chk("status", 32'h0, {30'h0, rdata[1:0]});
  endtask : mrs
  // Termination control must stay low at any MRS while termination is on
  always @(posedge ref_clk_in)
    if (rtt_on && mrp_if_i.cs_n === 1'b0)
      chk("odt", 32'h0, {31'h0, mrp_if_i.odt});
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (30000) @(posedge ref_clk_in);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    repeat (12) @(posedge ref_clk_in);
    chk("reset", 32'h1, {bl, cl, wr, mr1, mrp_if_i.cs_n});
    reset_n_in <= 1'b1;
    // Table rows: every burst, order and latency code, recovery codes 1 to 6
    foreach (rows[i])
    begin
      mrs(2'h0, rows[i].a, 1'b0);
      chk("mr0", {rows[i].bl, rows[i].otf, rows[i].rbo, rows[i].cl,
        rows[i].wr, 6'(rows[i].wr) + 6'(`MRP_TRP_CYC), rows[i].powerdown_dll_exit_select},
        {bl, otf, rbo, cl, wr, dal, powerdown_dll_exit_select});
    end
    // Other registers with termination on; mode register 0 is untouched
    for (int s = 1; s < 4; s++)
      mrs(s[1:0], 16'h0040 + 16'(s), 1'b1);
    chk("mr1", 32'h41, {16'h0, mr1});
    chk("mr2", 32'h42, {16'h0, mr2});
    chk("mr3", 32'h43, {16'h0, mr3});
    chk("mr0 kept", 32'h6, {27'h0, wr});
    // Test mode and reserved bits requested; the link must carry zeros
    mrs(2'h0, 16'he290, 1'b0);
    chk("test mode", 32'h0, {30'h0, tm, cerr});
    // Address word reads back as written, reserved bits included
    apb(1'b0, `MRP_REG_DATA, 32'h0);
    chk("data", 32'h0000e290, rdata);
    apb(1'b0, 12'h00c, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    // Back-to-back orders, the second one starting a DLL reset
    apb(1'b1, `MRP_REG_CTRL, 32'h1);
    mrs(2'h0, 16'h0310, 1'b0);
    chk("dll early", 32'h0, {31'h0, lock});
    repeat (`MRP_TDLLK_CYC) @(posedge ref_clk_in);
    chk("dll lock", 32'h1, {31'h0, lock});
    // Reset in mid-run: copies cleared, then a register is loaded again
    reset_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    chk("reset again", 32'h1, {bl, cl, wr, mr1, mrp_if_i.cs_n});
    reset_n_in <= 1'b1;
    mrs(2'h1, 16'h0041, 1'b0);
    chk("mr1 reload", 32'h41, {16'h0, mr1});
    finish_test();
  end
endmodule : mode_register_programming_tb
